// *** rtl/byte_alu_subset_ops.sv ***
/*
 Datapath for subtract with borrow, nibble exchange, xor immediate, xor
 register and port direction load, with accumulator, flags and the three
 port direction registers. Assumes decode presents a request with op_valid
 and that the file register write port accepts reg_wr in the same cycle.
*/
// Contract
// - Subtract with borrow computes register minus accumulator minus inverted carry.
// - That subtraction is 8-bit two's complement with inverted carry as the borrow input.
// - Nibble exchange swaps register nibbles and changes no flag.
// - Register instructions write the accumulator when target is 0, the register when 1.
// - Xor immediate xors the accumulator with an 8-bit literal into the accumulator.
// - Xor register xors accumulator with the indexed register and routes by target.
// - Port direction load copies the accumulator to a direction register, no flags.
// - Direction selector 5, 6, 7 picks port A, B, C; other values load nothing and pulse bad_selector.
module byte_alu_subset_ops
	import byte_alu_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Request from decode
	input wire logic op_valid,
	input wire alu_req_s req,
	// File register write back
	output logic reg_wr,
	output logic [ADDR_W-1:0] reg_wr_index,
	output logic [DATA_W-1:0] reg_wr_data,
	// Core state
	output logic [DATA_W-1:0] acc,
	output alu_flags_s flags,
	output logic [DATA_W-1:0] port_a_direction,
	output logic [DATA_W-1:0] port_b_direction,
	output logic [DATA_W-1:0] port_c_direction,
	output logic bad_selector
);

	//----------------------------------------
	// Compute
	//----------------------------------------
	logic [DATA_W-1:0] result;
	alu_flags_s new_flags;

	byte_alu_compute u_compute
	(
		.op(req.op),
		.acc(acc),
		.reg_operand(req.reg_operand),
		.literal(req.literal),
		.carry_in(flags.carry),
		.result(result),
		.flags(new_flags)
	);

	//----------------------------------------
	// Decode helpers
	//----------------------------------------
	// Operations whose result follows target_select
	function automatic logic routes_by_target(alu_op_e op);
		routes_by_target = (op == OP_SUBTRACT_WITH_BORROW)
			|| (op == OP_NIBBLE_EXCHANGE)
			|| (op == OP_XOR_REGISTER);
	endfunction : routes_by_target

	// Operations that load the zero flag from their result
	function automatic logic loads_zero(alu_op_e op);
		loads_zero = (op == OP_SUBTRACT_WITH_BORROW)
			|| (op == OP_XOR_IMMEDIATE)
			|| (op == OP_XOR_REGISTER);
	endfunction : loads_zero

	// One-hot pick of a direction register, bit 0 for port A
	function automatic logic [2:0] direction_pick(logic [ADDR_W-1:0] sel);
		case (sel)
			SEL_PORT_A: direction_pick = 3'h1;
			SEL_PORT_B: direction_pick = 3'h2;
			SEL_PORT_C: direction_pick = 3'h4;
			default: direction_pick = 3'h0;
		endcase
	endfunction : direction_pick

	//----------------------------------------
	// Request decode
	//----------------------------------------
	logic take_routed;
	logic take_immediate;
	logic take_direction;
	logic take_zero;
	logic take_subtract;
	logic [2:0] dir_hit;

	always_comb
	begin
		take_routed = op_valid && routes_by_target(req.op);
		take_immediate = op_valid && (req.op == OP_XOR_IMMEDIATE);
		take_direction = op_valid && (req.op == OP_PORT_DIRECTION_LOAD);
		take_zero = op_valid && loads_zero(req.op);
		take_subtract = op_valid && (req.op == OP_SUBTRACT_WITH_BORROW);
		dir_hit = direction_pick(req.reg_index);
	end

	//----------------------------------------
	// Accumulator
	//----------------------------------------
	logic [DATA_W-1:0] next_acc;

	always_comb
	begin
		next_acc = acc;
		if (take_immediate)
			next_acc = result;
		else if (take_routed && (req.target_select == TARGET_ACC))
			next_acc = result;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			acc <= ACC_RESET;
		else
			acc <= next_acc;
	end

	//----------------------------------------
	// Status flags
	//----------------------------------------
	alu_flags_s next_flags;

	always_comb
	begin
		// Nibble exchange and direction load keep every flag
		next_flags = flags;
		if (take_zero)
			next_flags.zero = new_flags.zero;
		if (take_subtract)
		begin
			next_flags.carry = new_flags.carry;
			next_flags.half_carry = new_flags.half_carry;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			flags <= '{carry: FLAG_RESET, half_carry: FLAG_RESET, zero: FLAG_RESET};
		else
			flags <= next_flags;
	end

	//----------------------------------------
	// File register write back
	//----------------------------------------
	logic next_reg_wr;
	logic [ADDR_W-1:0] next_reg_wr_index;
	logic [DATA_W-1:0] next_reg_wr_data;

	always_comb
	begin
		// Index and data load every cycle; only reg_wr qualifies them
		next_reg_wr = take_routed && (req.target_select == TARGET_REG);
		next_reg_wr_index = req.reg_index;
		next_reg_wr_data = result;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			reg_wr <= PULSE_RESET;
			reg_wr_index <= INDEX_RESET;
			reg_wr_data <= WB_DATA_RESET;
		end
		else
		begin
			reg_wr <= next_reg_wr;
			reg_wr_index <= next_reg_wr_index;
			reg_wr_data <= next_reg_wr_data;
		end
	end

	//----------------------------------------
	// Port direction registers
	//----------------------------------------
	logic [DATA_W-1:0] next_port_a_direction;
	logic [DATA_W-1:0] next_port_b_direction;
	logic [DATA_W-1:0] next_port_c_direction;
	logic next_bad_selector;

	always_comb
	begin
		next_port_a_direction = port_a_direction;
		next_port_b_direction = port_b_direction;
		next_port_c_direction = port_c_direction;
		next_bad_selector = 1'b0;
		if (take_direction)
		begin
			if (dir_hit[0])
				next_port_a_direction = acc;
			if (dir_hit[1])
				next_port_b_direction = acc;
			if (dir_hit[2])
				next_port_c_direction = acc;
			// Selectors outside 5 to 7 load nothing and raise a one-cycle pulse
			next_bad_selector = (dir_hit == 3'h0);
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			port_a_direction <= DIR_RESET;
			port_b_direction <= DIR_RESET;
			port_c_direction <= DIR_RESET;
			bad_selector <= PULSE_RESET;
		end
		else
		begin
			port_a_direction <= next_port_a_direction;
			port_b_direction <= next_port_b_direction;
			port_c_direction <= next_port_c_direction;
			bad_selector <= next_bad_selector;
		end
	end

endmodule : byte_alu_subset_ops

// *** rtl/byte_alu_pkg.sv ***
/*
 Package for the byte ALU subset: operation codes, field widths, reset values
 and the packed request and flag carriers shared by the datapath files.
 Assumes instruction decode supplies one operation request per cycle.
*/
package byte_alu_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;

	typedef enum logic [2:0]
	{
		OP_NONE = 3'b000,
		OP_SUBTRACT_WITH_BORROW = 3'b001,
		OP_NIBBLE_EXCHANGE = 3'b010,
		OP_XOR_IMMEDIATE = 3'b011,
		OP_XOR_REGISTER = 3'b100,
		OP_PORT_DIRECTION_LOAD = 3'b101
	} alu_op_e;

	// Port direction selectors
	localparam logic [ADDR_W-1:0] SEL_PORT_A = 7'h05;
	localparam logic [ADDR_W-1:0] SEL_PORT_B = 7'h06;
	localparam logic [ADDR_W-1:0] SEL_PORT_C = 7'h07;

	// Reset values
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic PULSE_RESET = 1'b0;
	localparam logic [ADDR_W-1:0] INDEX_RESET = 7'h00;
	localparam logic [DATA_W-1:0] WB_DATA_RESET = 8'h00;

	localparam logic TARGET_ACC = 1'b0;
	localparam logic TARGET_REG = 1'b1;

	typedef struct packed
	{
		alu_op_e op;
		logic target_select;
		logic [ADDR_W-1:0] reg_index;
		logic [DATA_W-1:0] reg_operand;
		logic [DATA_W-1:0] literal;
	} alu_req_s;

	typedef struct packed
	{
		logic carry;
		logic half_carry;
		logic zero;
	} alu_flags_s;

endpackage : byte_alu_pkg

// *** rtl/byte_alu_compute.sv ***
/*
 Combinational result and flag generator for one operation.
 Assumes the caller registers the result and chooses which flags to keep.
*/
module byte_alu_compute
	import byte_alu_pkg::*;
(
	// Operation
	input wire alu_op_e op,
	input wire logic [DATA_W-1:0] acc,
	input wire logic [DATA_W-1:0] reg_operand,
	input wire logic [DATA_W-1:0] literal,
	input wire logic carry_in,
	// Result
	output logic [DATA_W-1:0] result,
	output alu_flags_s flags
);

	logic [DATA_W:0] diff;
	logic [4:0] low_diff;

	always_comb
	begin
		// Borrow is the inverted carry; add ~acc plus carry is f - w - !c
		diff = {1'b0, reg_operand} + {1'b0, ~acc} + {8'h00, carry_in};
		low_diff = {1'b0, reg_operand[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, carry_in};
		flags.carry = diff[DATA_W];
		flags.half_carry = low_diff[4];
		case (op)
			OP_SUBTRACT_WITH_BORROW: result = diff[DATA_W-1:0];
			OP_NIBBLE_EXCHANGE: result = {reg_operand[3:0], reg_operand[7:4]};
			OP_XOR_IMMEDIATE: result = acc ^ literal;
			OP_XOR_REGISTER: result = acc ^ reg_operand;
			default: result = acc;
		endcase
		flags.zero = (result == 8'h00);
	end

endmodule : byte_alu_compute

// *** verification/byte_alu_subset_ops_properties.sv ***
/* Port assertions for byte_alu_subset_ops.
 Assumes one clock domain and an active high reset. */
module byte_alu_props
	import byte_alu_pkg::*;
(
	// Clock, reset and request
	input wire logic mclk,
	input wire logic reset,
	input wire logic op_valid,
	input wire alu_req_s req,
	// Pulses
	input wire logic reg_wr,
	input wire logic bad_selector,
	// State
	input wire alu_flags_s flags,
	input wire logic [ADDR_W-1:0] reg_wr_index,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic [DATA_W-1:0] acc,
	input wire logic [DATA_W-1:0] port_a_direction,
	input wire logic [DATA_W-1:0] port_b_direction,
	input wire logic [DATA_W-1:0] port_c_direction
);
	wire logic [DATA_W-1:0] f = req.reg_operand;
	// Expected sum f + ~acc + carry
	wire logic [8:0] s = {1'b0, f} + {1'b0, ~acc} + 9'(flags.carry);
	wire logic [4:0] h = {1'b0, f[3:0]} + {1'b0, ~acc[3:0]} + 5'(flags.carry);
	wire logic [7:0] d = s[7:0], w = {f[3:0], f[7:4]}, x = acc ^ req.literal, y = acc ^ f;
	wire logic c = s[8], hc = h[4], t = req.target_select;
	wire logic [6:0] ri = req.reg_index;
	wire logic sub = op_valid && req.op == OP_SUBTRACT_WITH_BORROW;
	wire logic nib = op_valid && req.op == OP_NIBBLE_EXCHANGE;
	wire logic xi = op_valid && req.op == OP_XOR_IMMEDIATE;
	wire logic xr = op_valid && req.op == OP_XOR_REGISTER;
	wire logic pd = op_valid && req.op == OP_PORT_DIRECTION_LOAD;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_sub_result: assert property (sub && !t |=> acc == $past(d)) else $error("sub");
	a_sub_flags: assert property (sub |=> flags.carry == $past(c)
		&& flags.half_carry == $past(hc)) else $error("sub flags");
	a_swap_nibbles: assert property (nib && !t |=> acc == $past(w)
		&& $stable(flags)) else $error("swap");
	a_reg_target: assert property ((sub || nib || xr) && t |=> reg_wr
		&& reg_wr_index == $past(ri) && $stable(acc)) else $error("target");
	a_xor_imm: assert property (xi |=> acc == $past(x) && !reg_wr) else $error("xori");
	a_xor_reg: assert property (xr && t |=> reg_wr_data == $past(y)) else $error("xorr");
	a_dir_flags: assert property (pd |=> $stable(flags) && !reg_wr) else $error("dirf");
	a_dir_select: assert property (pd && ri == SEL_PORT_C |=> port_c_direction
		== $past(acc) && $stable(port_a_direction)) else $error("dir");
	a_dir_refuse: assert property (pd && (ri < SEL_PORT_A || ri > SEL_PORT_C) |=> bad_selector
		&& $stable(port_b_direction)) else $error("dir refuse");
	a_zero_flag: assert property (xi |=> flags.zero == (acc == 8'h00)) else $error("z");
	cover property (reg_wr);
	cover property (bad_selector);
	cover property (pd && ri == SEL_PORT_A);
endmodule : byte_alu_props

bind byte_alu_subset_ops byte_alu_props u_props
(
	.mclk(mclk),
	.reset(reset),
	.op_valid(op_valid),
	.req(req),
	.reg_wr(reg_wr),
	.bad_selector(bad_selector),
	.flags(flags),
	.reg_wr_index(reg_wr_index),
	.reg_wr_data(reg_wr_data),
	.acc(acc),
	.port_a_direction(port_a_direction),
	.port_b_direction(port_b_direction),
	.port_c_direction(port_c_direction)
);

// *** verification/byte_alu_subset_ops_tb.sv ***
/* Self-checking bench for byte_alu_subset_ops.
 Assumes the checker file is compiled alongside. */
module byte_alu_subset_ops_tb
	import byte_alu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, reset = 1'b1, op_valid = 1'b0, reg_wr, bad_selector;
	alu_req_s req = '0;
	logic [ADDR_W-1:0] reg_wr_index;
	logic [DATA_W-1:0] reg_wr_data, acc, port_a_direction, port_b_direction, port_c_direction;
	alu_flags_s flags;
	int n_mismatch = 0, n_tests = 0;
	always #20 mclk = ~mclk;
	byte_alu_subset_ops DUT
	(
		.mclk(mclk),
		.reset(reset),
		.op_valid(op_valid),
		.req(req),
		.reg_wr(reg_wr),
		.reg_wr_index(reg_wr_index),
		.reg_wr_data(reg_wr_data),
		.acc(acc),
		.flags(flags),
		.port_a_direction(port_a_direction),
		.port_b_direction(port_b_direction),
		.port_c_direction(port_c_direction),
		.bad_selector(bad_selector)
	);
	task automatic chk(logic [23:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic go(alu_op_e o, logic t, logic [6:0] i, logic [7:0] f, l);
		@(posedge mclk);
		op_valid <= 1'b1;
		req <= '{o, t, i, f, l};
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
	endtask : go
	task automatic t_sub_swap;
		go(OP_XOR_IMMEDIATE, 1'b0, 7'h00, 8'h00, 8'h03);
		go(OP_SUBTRACT_WITH_BORROW, 1'b0, 7'h01, 8'h05, 8'h00);
		chk({acc, 13'h0, flags}, {8'h01, 13'h0, 3'b110});
		go(OP_NIBBLE_EXCHANGE, 1'b0, 7'h02, 8'hA5, 8'h00);
		chk({acc, 13'h0, flags}, {8'h5A, 13'h0, 3'b110});
		go(OP_NIBBLE_EXCHANGE, 1'b1, 7'h03, 8'h3C, 8'h00);
		chk({reg_wr, reg_wr_index, reg_wr_data, acc}, 24'h83C35A);
		go(OP_SUBTRACT_WITH_BORROW, 1'b1, 7'h7F, 8'h05, 8'h00);
		chk({reg_wr, reg_wr_index, reg_wr_data, acc}, 24'hFFAB5A);
		chk({21'h0, flags}, 24'h0);
		go(OP_SUBTRACT_WITH_BORROW, 1'b0, 7'h01, 8'h5B, 8'h00);
		chk({acc, 13'h0, flags}, {8'h00, 13'h0, 3'b111});
	endtask : t_sub_swap
	task automatic t_xor;
		go(OP_XOR_IMMEDIATE, 1'b1, 7'h04, 8'h00, 8'h5A);
		chk({acc, 12'h0, reg_wr, flags}, {8'h5A, 12'h0, 1'b0, 3'b110});
		go(OP_XOR_REGISTER, 1'b1, 7'h12, 8'h5A, 8'h00);
		chk({reg_wr, reg_wr_index, reg_wr_data, acc}, 24'h92005A);
		chk({21'h0, flags}, 24'h7);
		go(OP_XOR_REGISTER, 1'b0, 7'h13, 8'h0F, 8'h00);
		chk({acc, 13'h0, flags}, {8'h55, 13'h0, 3'b110});
	endtask : t_xor
	task automatic t_dir;
		go(OP_PORT_DIRECTION_LOAD, 1'b0, 7'h04, 8'h00, 8'h00);
		chk({23'h0, bad_selector}, 24'h1);
		chk({port_a_direction, port_b_direction, port_c_direction}, 24'hFFFFFF);
		go(OP_PORT_DIRECTION_LOAD, 1'b0, SEL_PORT_B, 8'h00, 8'h00);
		chk({port_a_direction, port_b_direction, port_c_direction}, 24'hFF55FF);
		go(OP_PORT_DIRECTION_LOAD, 1'b0, SEL_PORT_A, 8'h00, 8'h00);
		go(OP_PORT_DIRECTION_LOAD, 1'b0, SEL_PORT_C, 8'h00, 8'h00);
		chk({port_a_direction, port_b_direction, port_c_direction}, 24'h555555);
		chk({21'h0, flags}, 24'h6);
	endtask : t_dir
	task automatic t_edge;
		// Enters with acc 55, carry and half carry set; here carry and half carry differ
		go(OP_SUBTRACT_WITH_BORROW, 1'b0, 7'h20, 8'h60, 8'h00);
		chk({acc, 13'h0, flags}, {8'h0B, 13'h0, 3'b100});
		go(OP_XOR_IMMEDIATE, 1'b0, 7'h00, 8'h00, 8'h0B);
		chk({acc, 13'h0, flags}, {8'h00, 13'h0, 3'b101});
		// Unused and empty operation codes change nothing
		go(alu_op_e'(3'h6), 1'b1, SEL_PORT_A, 8'hFF, 8'hFF);
		chk({acc, 11'h0, flags, reg_wr, bad_selector}, {8'h00, 11'h0, 3'b101, 2'b00});
		go(OP_NONE, 1'b1, SEL_PORT_A, 8'hFF, 8'hFF);
		chk({acc, 11'h0, flags, reg_wr, bad_selector}, {8'h00, 11'h0, 3'b101, 2'b00});
		chk({port_a_direction, port_b_direction, port_c_direction}, 24'h555555);
	endtask : t_edge
	task automatic summarize;
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		#1;
		chk({acc, 11'h0, flags, reg_wr, bad_selector}, 24'h0);
		chk({port_a_direction, port_b_direction, port_c_direction}, 24'hFFFFFF);
		t_sub_swap();
		t_xor();
		t_dir();
		t_edge();
		summarize();
	end
endmodule : byte_alu_subset_ops_tb
